// File: uct_channel.sv
// uart channel core: apb registers, tx fifo and shifter, rx sampler, fifo and timeout
// assumes clock is the oversampling clock and serial input is asynchronous
//
// The APB register port is this design's own decision.
module uct_channel #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [5:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial line and transceiver
	input  wire logic        serialIn,
	output logic             serialOut,
	output logic             dirOut,
	output logic             irqOut
);
	logic [7:0] ierReg, fcrReg, lcrReg, mcrReg, msrwReg, sprReg, fctrReg, efrReg, dldReg;
	logic [7:0] txTrigReg, rxTrigReg, xoff1Reg, xoff2Reg, xon1Reg, xon2Reg;
	logic [7:0] txMem [DEPTH];
	uct_pkg::uct_rxword_t rxMem [DEPTH];
	logic [AW-1:0] txRd, txWr, rxRd, rxWr;
	logic [AW:0]   tx_fifo_level_count, rx_fifo_level_count;
	logic [7:0] holdReg;
	logic       holdFull;
	logic       overrunReg;
	logic       thrEmptyIrq;
	// bus decode
	logic acc, wr, rd;
	logic [3:0] idx;
	logic enh, fifoOn;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign idx = paddr[5:2];
	assign enh = efrReg[uct_pkg::EFR_ENH_BIT];
	assign fifoOn = fcrReg[uct_pkg::FCR_EN_BIT];
	logic divSel;
	assign divSel = lcrReg[7];
	logic thrWr, rhrRd;
	assign thrWr = wr && idx == uct_pkg::IDX_DATA && !divSel;
	assign rhrRd = rd && idx == uct_pkg::IDX_DATA && !divSel && !pready;

	// oversampling ratio from feature bits 7:6
	uct_pkg::uct_os_t osMode;
	logic [4:0] bitLen;
	assign osMode = uct_pkg::uct_os_t'(fctrReg[uct_pkg::FEATURE_CTRL_REG_OS_LSB +: 2]);
	always_comb begin
		case (osMode)
			uct_pkg::UCT_OS8: bitLen = 5'd8;
			uct_pkg::UCT_OS4: bitLen = 5'd4;
			default:          bitLen = 5'd16;
		endcase
	end

	// word length in bits for the timeout
	logic [3:0] wordBits;
	assign wordBits = 4'd7 + {2'b00, lcrReg[1:0]} + {3'b000, lcrReg[uct_pkg::LCR_PEN_BIT]}
		+ {3'b000, lcrReg[uct_pkg::LCR_STOP_BIT]};

	// register writes, enhanced bits masked unless enabled
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ierReg <= uct_pkg::RST_ZERO; fcrReg <= uct_pkg::RST_ZERO;
			lcrReg <= uct_pkg::RST_LCR; mcrReg <= uct_pkg::RST_ZERO;
			msrwReg <= uct_pkg::RST_ZERO; sprReg <= uct_pkg::RST_ZERO;
			fctrReg <= uct_pkg::RST_ZERO; efrReg <= uct_pkg::RST_ZERO;
			dldReg <= uct_pkg::RST_ZERO; txTrigReg <= uct_pkg::RST_ZERO;
			rxTrigReg <= uct_pkg::RST_ZERO; xoff1Reg <= uct_pkg::RST_ZERO;
			xoff2Reg <= uct_pkg::RST_ZERO; xon1Reg <= uct_pkg::RST_ZERO;
			xon2Reg <= uct_pkg::RST_ZERO;
		end else if (wr && !pready) begin
			if (idx == uct_pkg::IDX_IER && !divSel) begin
				ierReg <= enh ? {pwdata[7:5], 1'b0, pwdata[3:0]} : {ierReg[7:4], pwdata[3:0]};
			end else if (idx == uct_pkg::IDX_FCR && !divSel) begin
				fcrReg <= enh ? pwdata[7:0] : {pwdata[7:6], fcrReg[5:4], pwdata[3:0]};
			end else if (idx == uct_pkg::IDX_FCR && divSel) begin
				dldReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_LCR) begin
				lcrReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_MCR) begin
				mcrReg <= enh ? pwdata[7:0] : {mcrReg[7:5], pwdata[4:0]};
			end else if (idx == uct_pkg::IDX_MSR && enh) begin
				msrwReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_SPR) begin
				sprReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_FEATURE_CTRL_REG) begin
				fctrReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_EFR) begin
				efrReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_TX_FIFO_LEVEL_COUNT) begin
				txTrigReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_RX_FIFO_LEVEL_COUNT) begin
				rxTrigReg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_XCHAR) begin
				xoff1Reg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_STOP_FLOW_CHAR_TWO) begin
				xoff2Reg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_RESUME_FLOW_CHAR_ONE) begin
				xon1Reg <= pwdata[7:0];
			end else if (idx == uct_pkg::IDX_RESUME_FLOW_CHAR_TWO) begin
				xon2Reg <= pwdata[7:0];
			end
		end
	end

	// transmit shifter state
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} uct_txst_t;
	uct_txst_t txState;
	logic [7:0] tsrReg;
	logic [4:0] txTick;
	logic [2:0] txBit;
	logic       txStop2;
	logic       txPar;
	logic       txLoad;
	logic [7:0] txNextByte;
	logic       txSrcAvail;
	logic       tickEnd;
	assign tickEnd = txTick == bitLen - 5'd1;
	assign txSrcAvail = fifoOn ? (tx_fifo_level_count != '0) : holdFull;
	assign txNextByte = fifoOn ? txMem[txRd] : holdReg;
	assign txLoad = (txState == TX_IDLE) && txSrcAvail;

	// tx fifo and holding register, fifo writes only when enabled
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			txRd <= '0; txWr <= '0; tx_fifo_level_count <= '0; holdReg <= uct_pkg::RST_ZERO; holdFull <= 1'b0;
		end else if (wr && !pready && idx == uct_pkg::IDX_FCR && !divSel
			&& pwdata[uct_pkg::FCR_TXRST_BIT]) begin
			txRd <= '0; txWr <= '0; tx_fifo_level_count <= '0;
		end else begin
			if (thrWr && !pready && fifoOn && tx_fifo_level_count != DEPTH[AW:0]) begin
				txMem[txWr] <= pwdata[7:0];
				txWr <= txWr + 1'b1;
			end
			if (thrWr && !pready && !fifoOn) begin
				holdReg <= pwdata[7:0];
				holdFull <= 1'b1;
			end else if (txLoad && !fifoOn) begin
				holdFull <= 1'b0;
			end
			if (txLoad && fifoOn) begin
				txRd <= txRd + 1'b1;
			end
			tx_fifo_level_count <= tx_fifo_level_count + (AW+1)'(thrWr && !pready && fifoOn && tx_fifo_level_count != DEPTH[AW:0])
				- (AW+1)'(txLoad && fifoOn);
		end
	end

	// serial transmit, lsb first
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			txState <= TX_IDLE; tsrReg <= uct_pkg::RST_ZERO; txTick <= '0;
			txBit <= '0; txStop2 <= 1'b0; txPar <= 1'b0; serialOut <= 1'b1;
		end else begin
			case (txState)
				TX_IDLE: begin
					serialOut <= 1'b1;
					txTick <= '0;
					if (txLoad) begin
						tsrReg <= txNextByte;
						txState <= TX_START;
						serialOut <= 1'b0;
						txPar <= ^txNextByte ^ ~lcrReg[uct_pkg::LCR_EVEN_BIT];
					end
				end
				TX_START: begin
					txTick <= tickEnd ? '0 : txTick + 5'd1;
					if (tickEnd) begin
						txState <= TX_DATA;
						serialOut <= tsrReg[0];
						txBit <= '0;
					end
				end
				TX_DATA: begin
					txTick <= tickEnd ? '0 : txTick + 5'd1;
					if (tickEnd) begin
						tsrReg <= {1'b0, tsrReg[7:1]};
						txBit <= txBit + 3'd1;
						if (txBit == {1'b1, lcrReg[1:0]}) begin
							if (lcrReg[uct_pkg::LCR_PEN_BIT]) begin
								txState <= TX_PAR;
								serialOut <= lcrReg[uct_pkg::LCR_FORCE_BIT]
									? ~lcrReg[uct_pkg::LCR_EVEN_BIT] : txPar;
							end else begin
								txState <= TX_STOP;
								serialOut <= 1'b1;
								txStop2 <= lcrReg[uct_pkg::LCR_STOP_BIT];
							end
						end else begin
							serialOut <= tsrReg[1];
						end
					end
				end
				TX_PAR: begin
					txTick <= tickEnd ? '0 : txTick + 5'd1;
					if (tickEnd) begin
						txState <= TX_STOP;
						serialOut <= 1'b1;
						txStop2 <= lcrReg[uct_pkg::LCR_STOP_BIT];
					end
				end
				TX_STOP: begin
					txTick <= tickEnd ? '0 : txTick + 5'd1;
					serialOut <= 1'b1;
					if (tickEnd) begin
						txStop2 <= 1'b0;
						if (!txStop2) begin
							txState <= TX_IDLE;
						end
					end
				end
				default: txState <= TX_IDLE;
			endcase
			if (lcrReg[uct_pkg::LCR_BRK_BIT]) begin
				serialOut <= 1'b0; // break holds the line low
			end
		end
	end

	// status flags
	logic thrEmpty, tsrEmpty;
	assign thrEmpty = fifoOn ? (tx_fifo_level_count == '0) : !holdFull;
	assign tsrEmpty = thrEmpty && txState == TX_IDLE;

	// rs-485 direction with bit-time turnaround delay
	logic [3:0] dlyBits;
	logic [4:0] dlyTick;
	logic       dirActive;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dirActive <= 1'b0; dlyBits <= '0; dlyTick <= '0; dirOut <= 1'b0;
		end else begin
			if (!tsrEmpty) begin
				dirActive <= 1'b1;
				dlyBits <= msrwReg[7:4];
				dlyTick <= '0;
			end else if (dirActive) begin
				if (dlyBits == '0) begin
					dirActive <= 1'b0;
				end else if (dlyTick == bitLen - 5'd1) begin
					dlyTick <= '0;
					dlyBits <= dlyBits - 4'd1;
				end else begin
					dlyTick <= dlyTick + 5'd1;
				end
			end
			dirOut <= fctrReg[uct_pkg::FEATURE_CTRL_REG_485_BIT]
				? (dirActive ^ dldReg[uct_pkg::DLD_POL_BIT]) : 1'b0;
		end
	end

	// serial input synchroniser, first stage read only by the second
	logic rxMeta, rxSync;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxMeta <= 1'b1; rxSync <= 1'b1;
		end else begin
			rxMeta <= serialIn;
			rxSync <= rxMeta;
		end
	end
	logic rxLine;
	assign rxLine = mcrReg[4] ? serialOut : rxSync; // loopback

	// receive sampler
	logic       rxBusy;
	logic [4:0] rxTick;
	logic [3:0] rxBitNo;
	logic [8:0] rsrReg;
	logic       rxPush;
	uct_pkg::uct_rxword_t rxWord;
	logic [3:0] rxLast;
	assign rxLast = 4'd6 + {2'b00, lcrReg[1:0]} + {3'b000, lcrReg[uct_pkg::LCR_PEN_BIT]};
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxBusy <= 1'b0; rxTick <= '0; rxBitNo <= '0; rsrReg <= '0;
			rxPush <= 1'b0; rxWord <= '0;
		end else begin
			rxPush <= 1'b0;
			if (!rxBusy) begin
				rxTick <= '0;
				rxBitNo <= '0;
				if (!rxLine) begin
					rxBusy <= 1'b1;
				end
			end else if (rxTick == (bitLen >> 1) - 5'd1 && rxBitNo == '0) begin
				rxTick <= '0;
				if (rxLine) begin
					rxBusy <= 1'b0;
				end else begin
					rxBitNo <= 4'd1;
				end
			end else if (rxTick == bitLen - 5'd1 && rxBitNo != '0) begin
				rxTick <= '0;
				if (rxBitNo == rxLast) begin
					rxBusy <= 1'b0;
					rxPush <= 1'b1;
					rxWord.data <= rsrReg[7:0] >> (3'd3 - 3'(lcrReg[1:0]));
					rxWord.frm <= !rxLine;
					rxWord.brk <= !rxLine && rsrReg == '0;
					rxWord.par <= lcrReg[uct_pkg::LCR_PEN_BIT] && (lcrReg[uct_pkg::LCR_FORCE_BIT]
						? rsrReg[8] != ~lcrReg[uct_pkg::LCR_EVEN_BIT]
						: ^rsrReg[8:0] != ~lcrReg[uct_pkg::LCR_EVEN_BIT]);
				end else begin
					rxBitNo <= rxBitNo + 4'd1;
					rsrReg <= lcrReg[uct_pkg::LCR_PEN_BIT]
						? {rxLine, rsrReg[8:1]} : {1'b0, rxLine, rsrReg[7:1]};
				end
			end else begin
				rxTick <= rxTick + 5'd1;
			end
		end
	end

	// rx fifo; non-fifo mode uses a depth of one
	logic rxFull;
	assign rxFull = fifoOn ? (rx_fifo_level_count == DEPTH[AW:0]) : (rx_fifo_level_count != '0);
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxRd <= '0; rxWr <= '0; rx_fifo_level_count <= '0; overrunReg <= 1'b0;
		end else if (wr && !pready && idx == uct_pkg::IDX_FCR && !divSel
			&& pwdata[uct_pkg::FCR_RXRST_BIT]) begin
			rxRd <= '0; rxWr <= '0; rx_fifo_level_count <= '0;
		end else begin
			if (rxPush && !rxFull) begin
				rxMem[rxWr] <= rxWord;
				rxWr <= rxWr + 1'b1;
			end
			if (rhrRd && rx_fifo_level_count != '0) begin
				rxRd <= rxRd + 1'b1;
			end
			rx_fifo_level_count <= rx_fifo_level_count + (AW+1)'(rxPush && !rxFull) - (AW+1)'(rhrRd && rx_fifo_level_count != '0);
			// set wins over the clear from an lsr read
			if (rxPush && rxFull) begin
				overrunReg <= 1'b1;
			end else if (rd && !pready && idx == uct_pkg::IDX_LSR) begin
				overrunReg <= 1'b0;
			end
		end
	end

	// receive timeout counter in oversampling clocks
	logic [10:0] toutCnt;
	logic [10:0] toutLimit;
	logic        toutFlag;
	assign toutLimit = 11'(bitLen) * (11'(uct_pkg::TOUT_WORDS) * 11'(wordBits)
		+ 11'(uct_pkg::TOUT_EXTRA));
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			toutCnt <= '0; toutFlag <= 1'b0;
		end else if (rx_fifo_level_count == '0 || rxPush || rhrRd) begin
			toutCnt <= '0; toutFlag <= 1'b0;
		end else if (toutCnt >= toutLimit) begin
			toutFlag <= 1'b1;
		end else begin
			toutCnt <= toutCnt + 11'd1;
		end
	end

	// interrupt sources and priority encoding
	logic rxTrigHit, txIrq, rxIrq, lsIrq;
	logic [7:0] isrVal;
	uct_pkg::uct_rxword_t head;
	assign head = rxMem[rxRd];
	assign rxTrigHit = fifoOn ? (rx_fifo_level_count >= {1'b0, rxTrigReg} && rx_fifo_level_count != '0) : (rx_fifo_level_count != '0);
	assign rxIrq = ierReg[0] && rxTrigHit;
	assign lsIrq = ierReg[2] && rx_fifo_level_count != '0 && (head.par || head.frm || head.brk || overrunReg);
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			thrEmptyIrq <= 1'b0;
		end else if (fctrReg[uct_pkg::FEATURE_CTRL_REG_485_BIT]) begin
			thrEmptyIrq <= tsrEmpty;
		end else if (fifoOn) begin
			thrEmptyIrq <= tx_fifo_level_count < {1'b0, txTrigReg};
		end else begin
			thrEmptyIrq <= thrEmpty;
		end
	end
	assign txIrq = ierReg[1] && thrEmptyIrq;
	always_comb begin
		isrVal = {{2{fifoOn}}, 6'h01};
		if (lsIrq) begin
			isrVal[5:0] = 6'h06;
		end else if (ierReg[0] && toutFlag) begin
			isrVal[5:0] = 6'h0C;
		end else if (rxIrq) begin
			isrVal[5:0] = 6'h04;
		end else if (txIrq) begin
			isrVal[5:0] = 6'h02;
		end
	end

	// read data mux and a one wait-state answer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= '0; pready <= 1'b0; pslverr <= 1'b0; irqOut <= 1'b0;
		end else begin
			irqOut <= isrVal[0] == 1'b0;
			pready <= acc && !pready;
			pslverr <= 1'b0;
			prdata <= '0;
			if (rd && !pready) begin
				if (idx == uct_pkg::IDX_DATA) begin
					prdata[7:0] <= head.data;
				end else if (idx == uct_pkg::IDX_IER) begin
					prdata[7:0] <= ierReg;
				end else if (idx == uct_pkg::IDX_FCR) begin
					prdata[7:0] <= divSel ? dldReg : isrVal;
				end else if (idx == uct_pkg::IDX_LCR) begin
					prdata[7:0] <= lcrReg;
				end else if (idx == uct_pkg::IDX_MCR) begin
					prdata[7:0] <= mcrReg;
				end else if (idx == uct_pkg::IDX_LSR) begin
					prdata[7:0] <= {1'b0, tsrEmpty, thrEmpty, head.brk && rx_fifo_level_count != '0,
						head.frm && rx_fifo_level_count != '0, head.par && rx_fifo_level_count != '0, overrunReg,
						rx_fifo_level_count != '0};
				end else if (idx == uct_pkg::IDX_SPR) begin
					prdata[7:0] <= sprReg;
				end else if (idx == uct_pkg::IDX_FEATURE_CTRL_REG) begin
					prdata[7:0] <= fctrReg;
				end else if (idx == uct_pkg::IDX_EFR) begin
					prdata[7:0] <= efrReg;
				end else if (idx == uct_pkg::IDX_TX_FIFO_LEVEL_COUNT) begin
					prdata[7:0] <= tx_fifo_level_count[AW] ? 8'hFF : tx_fifo_level_count[7:0];
				end else if (idx == uct_pkg::IDX_RX_FIFO_LEVEL_COUNT) begin
					prdata[7:0] <= rx_fifo_level_count[AW] ? 8'hFF : rx_fifo_level_count[7:0];
				end
			end
		end
	end
endmodule

// File: uct_pkg.sv
// package for the uart channel core: register offsets, field positions, reset values
// assumes apb byte addresses of index times four
package uct_pkg;
	// register indices (byte address is four times the index)
	localparam logic [3:0] IDX_DATA     = 4'h0;
	localparam logic [3:0] IDX_IER      = 4'h1;
	localparam logic [3:0] IDX_FCR      = 4'h2;
	localparam logic [3:0] IDX_LCR      = 4'h3;
	localparam logic [3:0] IDX_MCR      = 4'h4;
	localparam logic [3:0] IDX_LSR      = 4'h5;
	localparam logic [3:0] IDX_MSR      = 4'h6;
	localparam logic [3:0] IDX_SPR      = 4'h7;
	localparam logic [3:0] IDX_FEATURE_CTRL_REG     = 4'h8;
	localparam logic [3:0] IDX_EFR      = 4'h9;
	localparam logic [3:0] IDX_TX_FIFO_LEVEL_COUNT    = 4'hA;
	localparam logic [3:0] IDX_RX_FIFO_LEVEL_COUNT    = 4'hB;
	localparam logic [3:0] IDX_XCHAR    = 4'hC;
	localparam logic [3:0] IDX_STOP_FLOW_CHAR_TWO    = 4'hD;
	localparam logic [3:0] IDX_RESUME_FLOW_CHAR_ONE     = 4'hE;
	localparam logic [3:0] IDX_RESUME_FLOW_CHAR_TWO     = 4'hF;
	// field positions
	localparam int EFR_ENH_BIT   = 4;
	localparam int FCR_EN_BIT    = 0;
	localparam int FCR_RXRST_BIT = 1;
	localparam int FCR_TXRST_BIT = 2;
	localparam int FEATURE_CTRL_REG_485_BIT  = 5;
	localparam int FEATURE_CTRL_REG_OS_LSB   = 6;
	localparam int LCR_STOP_BIT  = 2;
	localparam int LCR_PEN_BIT   = 3;
	localparam int LCR_EVEN_BIT  = 4;
	localparam int LCR_FORCE_BIT = 5;
	localparam int LCR_BRK_BIT   = 6;
	localparam int DLD_POL_BIT   = 7;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_LCR  = 8'h03;
	// timeout: four words plus this many bit times
	localparam int TOUT_WORDS = 4;
	localparam int TOUT_EXTRA = 12;
	// oversampling modes
	typedef enum logic [1:0] {
		UCT_OS16 = 2'b00,
		UCT_OS8  = 2'b01,
		UCT_OS4  = 2'b10
	} uct_os_t;
	// received byte with its error flags
	typedef struct packed {
		logic       brk;
		logic       frm;
		logic       par;
		logic [7:0] data;
	} uct_rxword_t;
endpackage

// File: uct_channel_properties.sv
// checker for the uart channel core: bus answers, serial bit timing, direction pin
// assumes only the channel ports; the divisor latch bit is never set by the bench
module uct_channel_properties (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [5:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// serial side
	input wire logic        serialIn,
	input wire logic        serialOut,
	input wire logic        dirOut,
	input wire logic        irqOut
);
	logic [1:0] osMode;
	logic       auto485;
	logic [3:0] enLow;
	logic       prevOut;
	logic [7:0] runCnt;
	logic [7:0] bitLen;
	logic       take;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	assign take = psel && penable && pwrite && !pready;
	assign bitLen = (osMode == 2'h0) ? 8'h10 : (osMode == 2'h1) ? 8'h08 : 8'h04;
	// shadow of the mode writes that shape the serial output
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			osMode  <= 2'h0;
			auto485 <= 1'b0;
		end else if (take && paddr[5:2] == 4'h8) begin
			osMode  <= pwdata[7:6];
			auto485 <= pwdata[5];
		end
	end
	// shadow of the low interrupt enables
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			enLow <= 4'h0;
		else if (take && paddr[5:2] == 4'h1)
			enLow <= pwdata[3:0];
	end
	// run length of one level, saturating so a long idle cannot wrap
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prevOut <= 1'b1;
			runCnt  <= 8'h00;
		end else begin
			prevOut <= serialOut;
			if (serialOut != prevOut)
				runCnt <= 8'h01;
			else if (runCnt != 8'hFF)
				runCnt <= runCnt + 8'h01;
		end
	end
	ready_wait_a: assert property (
		psel && penable && !pready |=> pready)
		else $error("no ready after wait state");
	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready held too long");
	rdata_idle_a: assert property (
		!(pready && !pwrite) |-> prdata == 32'h00000000)
		else $error("read data outside answer");
	bit_length_a: assert property (
		$rose(serialOut) |-> (runCnt & (bitLen - 8'h01)) == 8'h00)
		else $error("low run not whole bits");
	reset_idle_a: assert property (
		$rose(rst_b) |-> serialOut && !dirOut && !irqOut)
		else $error("outputs busy after reset");
	dir_tx_a: assert property (
		auto485 && !serialOut && !prevOut |-> dirOut)
		else $error("direction low in frame");
	dir_hold_a: assert property (
		$fell(dirOut) |-> serialOut && runCnt >= bitLen - 8'h01)
		else $error("direction dropped early");
	irq_mask_a: assert property (
		enLow == 4'h0 && $past(enLow) == 4'h0 && $past(enLow, 2) == 4'h0 |-> !irqOut)
		else $error("interrupt while all masked");
endmodule

bind uct_channel uct_channel_properties u_checks (
	.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serialIn(serialIn), .serialOut(serialOut), .dirOut(dirOut), .irqOut(irqOut)
);

// File: uct_serial_peer.sv
// remote serial station: sends frames to the channel and captures its frames
// assumes the shared oversampling clock; bit length in clocks is given per call
module uct_serial_peer (
	// clock
	input wire logic clock,
	// serial lines
	input wire logic txLine,
	output logic     rxLine
);
	initial rxLine = 1'b1;
	// start, data lsb first, stop level, then one idle bit to resync
	task automatic sendFrame(input logic [7:0] d, input int len, input logic stopLvl);
		logic [10:0] bits;
		bits = {1'b1, stopLvl, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clock);
			rxLine <= bits[i];
			repeat (len - 1) @(posedge clock);
		end
	endtask
	// one-clock low pulse, too short for a start bit
	task automatic glitch(input int idle);
		@(posedge clock);
		rxLine <= 1'b0;
		@(posedge clock);
		rxLine <= 1'b1;
		repeat (idle) @(posedge clock);
	endtask
	// find a start bit, then sample every later bit at its centre
	task automatic recvFrame(output logic [9:0] s, input int len, input logic pen);
		int n;
		n = 0;
		s = 10'h000;
		@(posedge clock);
		while (txLine !== 1'b0 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		repeat (len / 2) @(posedge clock);
		for (int i = 0; i < (pen ? 10 : 9); i++) begin
			repeat (len) @(posedge clock);
			s[i] = txLine;
		end
	endtask
endmodule

// File: uct_channel_tb.sv
// self-checking bench for the uart channel core: apb tasks and a serial peer
// assumes the checker binds itself and a 40 MHz oversampling clock
module uct_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst_b, psel, penable, pwrite;
	logic [5:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, serialIn, serialOut, dirOut, irqOut;
	logic [9:0]  got;
	logic [7:0]  txv [3];
	int          mismatches, check_count, cycles, n;
	uct_channel dut (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serialIn(serialIn), .serialOut(serialOut),
		.dirOut(dirOut), .irqOut(irqOut)
	);
	uct_serial_peer peer (.clock(clock), .txLine(serialOut), .rxLine(serialIn));
	// 25 ns period
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// hang guard, far above the roughly 1200 cycles needed
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until ready is sampled high
	task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
			chk("ready", 32'h0, 32'h1);
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdc(input string what, input logic [3:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(what, rd, {24'h000000, exp});
	endtask
	// reset values, a read-only write and the enhanced-bit gate
	task automatic testRegs();
		rdc("line ctrl reset", 4'h3, 8'h03);
		rdc("status reset", 4'h5, 8'h60);
		wr(4'h5, 8'hFF);
		rdc("status read only", 4'h5, 8'h60);
		wr(4'h1, 8'hE0);
		rdc("enable gated", 4'h1, 8'h00);
		wr(4'h9, 8'h10);
		wr(4'h1, 8'hE0);
		rdc("enable open", 4'h1, 8'hE0);
		wr(4'h1, 8'h00);
		wr(4'h9, 8'h00);
		$display("regs test done");
	endtask
	// holding byte moves to the shifter, then the shifter drains
	task automatic testTxPlain();
		fork
			peer.recvFrame(got, 16, 1'b0);
			begin
				wr(4'h0, 8'hA5);
				repeat (40) @(posedge clock);
				rdc("status shifting", 4'h5, 8'h20);
			end
		join
		chk("plain frame", {22'h0, got}, 32'h000001A5);
		repeat (20) @(posedge clock);
		rdc("status idle", 4'h5, 8'h60);
		$display("tx plain test done");
	endtask
	// fifo at 8x with even parity, three writes back to back
	task automatic testTxFifo();
		wr(4'h2, 8'h01);
		wr(4'h8, 8'h40);
		wr(4'h3, 8'h1B);
		fork
			for (int i = 0; i < 3; i++) begin
				peer.recvFrame(got, 8, 1'b1);
				chk("fifo frame", {22'h0, got}, {22'h0, 1'b1, ^txv[i], txv[i]});
			end
			begin
				for (int j = 0; j < 3; j++) wr(4'h0, txv[j]);
				rdc("status busy", 4'h5, 8'h00);
			end
		join
		repeat (20) @(posedge clock);
		rdc("status drained", 4'h5, 8'h60);
		wr(4'h3, 8'h03);
		$display("tx fifo test done");
	endtask
	// 4x receive: false start, framing error, clean byte
	task automatic testRx();
		wr(4'h8, 8'h80);
		peer.glitch(8);
		peer.sendFrame(8'hC3, 4, 1'b0);
		peer.sendFrame(8'h3C, 4, 1'b1);
		rdc("rx level", 4'hB, 8'h02);
		rdc("status bad head", 4'h5, 8'h69);
		rdc("rx first", 4'h0, 8'hC3);
		rdc("status next head", 4'h5, 8'h61);
		rdc("rx second", 4'h0, 8'h3C);
		$display("rx test done");
	endtask
	// one byte below trigger four: quiet until the time-out
	task automatic testTimeout();
		wr(4'hB, 8'h04);
		wr(4'h1, 8'h01);
		peer.sendFrame(8'h42, 4, 1'b1);
		repeat (150) @(posedge clock);
		chk("early irq", {31'h0, irqOut}, 32'h0);
		n = 0;
		while (irqOut !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk("time-out span", {31'h0, n >= 56 && n <= 64}, 32'h1);
		rdc("source time-out", 4'h2, 8'hCC);
		rdc("rx byte", 4'h0, 8'h42);
		wr(4'h1, 8'h00);
		$display("time-out test done");
	endtask
	// auto direction at 16x, two bit turnaround, shifter-empty interrupt
	task automatic test485();
		wr(4'h2, 8'h00);
		wr(4'h9, 8'h10);
		wr(4'h6, 8'h20);
		wr(4'h8, 8'h20);
		wr(4'h1, 8'h02);
		fork
			peer.recvFrame(got, 16, 1'b0);
			wr(4'h0, 8'h96);
		join
		chk("dir frame", {22'h0, got}, 32'h00000196);
		chk("dir and irq in stop", {30'h0, dirOut, irqOut}, 32'h2);
		n = 0;
		while (dirOut !== 1'b0 && n < 100) begin
			@(posedge clock);
			n++;
		end
		chk("turnaround", {31'h0, n >= 37 && n <= 43}, 32'h1);
		chk("irq after stop", {31'h0, irqOut}, 32'h1);
		wr(4'h1, 8'h00);
		$display("direction test done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// reset for ten cycles, then the scenarios in turn
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 6'h00;
		pwdata = 32'h00000000;
		mismatches = 0;
		check_count = 0;
		cycles = 0;
		txv = '{8'h81, 8'h7E, 8'h00};
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		testRegs();
		testTxPlain();
		testTxFifo();
		testRx();
		testTimeout();
		test485();
		test_done();
	end
endmodule
